/* File: design/cpmc_regs.vh */
// Purpose: constants for the clock and power mode controller
// Assumes: apb register map, 32-bit words, 250 MHz core clock
// Notes:   timing counts derived from times in microseconds
`ifndef CPMC_REGS_VH
`define CPMC_REGS_VH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define CPMC_OFF_MODE      12'h000
`define CPMC_OFF_STATUS    12'h004
`define CPMC_OFF_CONFIG    12'h008

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CPMC_MODE_SEL      0
`define CPMC_MODE_STOP     1
`define CPMC_MODE_PM_LO    2
`define CPMC_MODE_PM_HI    3
`define CPMC_MODE_T0LCK    4
`define CPMC_ST_PDN        3
`define CPMC_ST_TON        4

// ------------------------------------------------------------
// reset values and encodings
// ------------------------------------------------------------
`define CPMC_MODE_RST      8'h00
`define CPMC_PM_RUN        2'h0
`define CPMC_PM_HALT       2'h1
`define CPMC_PM_STBY       2'h2

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CPMC_CLK_MHZ       250
`define CPMC_SETTLE_CYC    16
`define CPMC_PWRUP_140U_US 140
`define CPMC_PWRUP_4M5_US  4500
`define CPMC_PWRUP_18M_US  18000
`define CPMC_PWRUP_72M_US  72000
`define CPMC_PWRUP_288M_US 288000

`endif

/* File: design/cpmc_top.v */
// Purpose: clock source select, operating modes, wake-up and reset sequencing
// Assumes: oscillator clocks arrive as synchronous enables at core_clk
// Notes:   apb slave, single clock domain, no interrupt logic of its own
`timescale 1ns/1ps
`include "cpmc_regs.vh"

module cpmc_top #(
  parameter integer PWRUP_140U_CYC = `CPMC_PWRUP_140U_US * `CPMC_CLK_MHZ,
  parameter integer PWRUP_4M5_CYC  = `CPMC_PWRUP_4M5_US * `CPMC_CLK_MHZ,
  parameter integer PWRUP_18M_CYC  = `CPMC_PWRUP_18M_US * `CPMC_CLK_MHZ,
  parameter integer PWRUP_72M_CYC  = `CPMC_PWRUP_72M_US * `CPMC_CLK_MHZ,
  parameter integer PWRUP_288M_CYC = `CPMC_PWRUP_288M_US * `CPMC_CLK_MHZ,
  parameter integer SETTLE_CYC     = `CPMC_SETTLE_CYC
) (
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        fast_osc_tick,
  input  wire        slow_osc_tick,
  input  wire        cfg_inst_div4,
  input  wire [2:0]  cfg_fast_freq,
  input  wire        cfg_startup_fast,
  input  wire [2:0]  cfg_pwrup_sel,
  input  wire        cfg_t0_slow_src,
  input  wire        cfg_wdt_reset,
  input  wire        por_event,
  input  wire        low_supply_reset,
  input  wire        ext_reset_pin_n,
  input  wire        wdt_timeout,
  input  wire        sleep_op,
  input  wire        watchdog_clear_op,
  input  wire        global_irq_allow,
  input  wire        timer0_ovf,
  input  wire        timer1_unf,
  input  wire        portb_change,
  input  wire        ext_pin_irq,
  input  wire        lvd_irq,
  output reg         fast_osc_en,
  output reg         slow_osc_en,
  output reg  [2:0]  fast_freq_sel,
  output reg         sys_clk_fast,
  output reg         inst_tick,
  output reg         cpu_run,
  output reg         periph_en,
  output reg         timer_en,
  output reg         timer0_slow_clk,
  output reg         wdt_clear,
  output reg         wake_vector,
  output reg         core_reset
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [2:0] ST_RST   = 3'h0;
  localparam [2:0] ST_PWRUP = 3'h1;
  localparam [2:0] ST_OST   = 3'h2;
  localparam [2:0] ST_RUN   = 3'h3;
  localparam [2:0] ST_STBY  = 3'h4;
  localparam [2:0] ST_HALT  = 3'h5;
  localparam [2:0] ST_WAKE  = 3'h6;

  function [31:0] pwrup_cycles;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    pwrup_cycles = PWRUP_140U_CYC;
        3'h1:    pwrup_cycles = PWRUP_4M5_CYC;
        3'h2:    pwrup_cycles = PWRUP_18M_CYC;
        3'h3:    pwrup_cycles = PWRUP_72M_CYC;
        default: pwrup_cycles = PWRUP_288M_CYC;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n = rst_s2_q;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  reg  [7:0]  mode_q;
  reg         to_n_q;
  reg         pd_n_q;
  reg  [2:0]  st_q;
  reg  [31:0] cnt_q;
  reg         sel_fast_q;
  reg         in_halt_q;
  reg         flags_init_q;
  reg         gie_sleep_q;

  wire wr_acc = psel && penable && pwrite;
  wire wr_mode = wr_acc && (paddr == `CPMC_OFF_MODE) && pstrb[0];
  wire [1:0] pm_wr = pwdata[`CPMC_MODE_PM_HI:`CPMC_MODE_PM_LO];
  wire reset_evt = por_event || low_supply_reset || !ext_reset_pin_n ||
                   (wdt_timeout && cfg_wdt_reset);
  wire stby_wake = timer0_ovf || timer1_unf || wdt_timeout ||
                   portb_change || ext_pin_irq || lvd_irq;
  wire halt_wake = wdt_timeout || portb_change || ext_pin_irq;
  wire sys_tick = sel_fast_q ? fast_osc_tick : slow_osc_tick;
  wire running = (st_q == ST_RUN);
  wire go_halt = running && (sleep_op || (wr_mode && pm_wr == `CPMC_PM_HALT));
  wire go_stby = running && wr_mode && pm_wr == `CPMC_PM_STBY;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // ------------------------------------------------------------
  // mode register and sequencer
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q       <= `CPMC_MODE_RST;
      st_q         <= ST_RST;
      cnt_q        <= 32'h0;
      in_halt_q    <= 1'b0;
      gie_sleep_q  <= 1'b0;
      flags_init_q <= 1'b0;
      to_n_q       <= 1'b1;
      pd_n_q       <= 1'b1;
    end else if (clk_en) begin
      if (!flags_init_q) begin
        flags_init_q <= 1'b1; // first power-on: both flags high
      end
      if (reset_evt) begin
        st_q   <= ST_RST;
        mode_q <= `CPMC_MODE_RST;
        cnt_q  <= 32'h0;
        if (por_event || low_supply_reset) begin
          to_n_q <= 1'b1;
          pd_n_q <= 1'b1;
        end else if (!ext_reset_pin_n) begin
          if (in_halt_q) begin
            to_n_q <= 1'b1;
            pd_n_q <= 1'b1;
          end
        end else begin
          to_n_q <= 1'b0;
          pd_n_q <= !in_halt_q;
        end
        in_halt_q <= 1'b0;
      end else begin
        if (wr_mode && st_q != ST_RST && st_q != ST_PWRUP && st_q != ST_OST) begin
          mode_q <= {pwdata[7:4], 2'b00, pwdata[1:0]};
        end
        if (watchdog_clear_op) begin
          to_n_q <= 1'b1;
          pd_n_q <= 1'b1;
        end
        if (wdt_timeout && !cfg_wdt_reset) begin
          to_n_q <= 1'b0;
        end
        case (st_q)
          ST_RST: begin
            st_q  <= ST_PWRUP;
            cnt_q <= pwrup_cycles(cfg_pwrup_sel);
          end
          ST_PWRUP: begin
            if (cnt_q <= 32'h1) begin
              st_q  <= ST_OST;
              cnt_q <= SETTLE_CYC;
            end else begin
              cnt_q <= cnt_q - 32'h1;
            end
          end
          ST_OST: begin
            if (sys_tick) begin
              if (cnt_q <= 32'h1) begin
                st_q <= ST_RUN;
                mode_q[`CPMC_MODE_SEL] <= cfg_startup_fast;
              end else begin
                cnt_q <= cnt_q - 32'h1;
              end
            end
          end
          ST_RUN: begin
            if (go_halt) begin
              st_q        <= ST_HALT;
              in_halt_q   <= 1'b1;
              pd_n_q      <= 1'b0;
              to_n_q      <= 1'b1;
              gie_sleep_q <= global_irq_allow;
            end else if (go_stby) begin
              st_q        <= ST_STBY;
              gie_sleep_q <= global_irq_allow;
            end
          end
          ST_STBY: begin
            if (stby_wake) begin
              st_q <= ST_RUN;
            end
          end
          ST_HALT: begin
            if (halt_wake) begin
              st_q      <= ST_WAKE;
              cnt_q     <= SETTLE_CYC;
              in_halt_q <= 1'b0;
            end
          end
          ST_WAKE: begin
            if (sys_tick) begin
              if (cnt_q <= 32'h1) begin
                st_q <= ST_RUN;
              end else begin
                cnt_q <= cnt_q - 32'h1;
              end
            end
          end
          default: st_q <= ST_RST;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // glitch-free source switch and instruction divider
  // ------------------------------------------------------------
  // switch only on a tick of the current source so no short system period is issued
  reg [1:0] div_q;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_fast_q <= 1'b0;
      div_q      <= 2'h0;
      inst_tick  <= 1'b0;
    end else if (clk_en) begin
      inst_tick <= 1'b0;
      if (sys_tick) begin
        if (sel_fast_q != mode_q[`CPMC_MODE_SEL]) begin
          sel_fast_q <= mode_q[`CPMC_MODE_SEL];
          div_q      <= 2'h0;
        end else begin
          div_q <= div_q + 2'h1;
          if (cpu_run && (cfg_inst_div4 ? (div_q == 2'h3) : div_q[0])) begin
            inst_tick <= 1'b1;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_osc_en     <= 1'b1;
      slow_osc_en     <= 1'b1;
      fast_freq_sel   <= 3'h0;
      sys_clk_fast    <= 1'b0;
      cpu_run         <= 1'b0;
      periph_en       <= 1'b0;
      timer_en        <= 1'b0;
      timer0_slow_clk <= 1'b0;
      wdt_clear       <= 1'b0;
      wake_vector     <= 1'b0;
      core_reset      <= 1'b1;
    end else if (clk_en) begin
      fast_freq_sel   <= cfg_fast_freq;
      // a stop request is honoured only once slow is really selected
      fast_osc_en     <= (st_q != ST_HALT) &&
                         !(mode_q[`CPMC_MODE_STOP] && !sel_fast_q);
      slow_osc_en     <= (st_q != ST_HALT);
      sys_clk_fast    <= sel_fast_q;
      cpu_run         <= running && !go_halt && !go_stby;
      periph_en       <= running || st_q == ST_STBY;
      timer_en        <= st_q != ST_HALT && st_q != ST_WAKE;
      timer0_slow_clk <= mode_q[`CPMC_MODE_T0LCK] && cfg_t0_slow_src &&
                         slow_osc_tick;
      wdt_clear       <= go_halt || watchdog_clear_op;
      wake_vector     <= gie_sleep_q &&
                         ((st_q == ST_STBY && stby_wake) ||
                          (st_q == ST_WAKE && sys_tick && cnt_q <= 32'h1));
      core_reset      <= st_q == ST_RST || st_q == ST_PWRUP || st_q == ST_OST;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `CPMC_OFF_MODE: begin
          prdata <= {24'h0, mode_q[7:4],
                     (st_q == ST_STBY) ? `CPMC_PM_STBY : `CPMC_PM_RUN, mode_q[1:0]};
        end
        `CPMC_OFF_STATUS: begin
          prdata <= {27'h0, to_n_q, pd_n_q, st_q};
        end
        `CPMC_OFF_CONFIG: begin
          prdata <= {24'h0, cfg_inst_div4, cfg_pwrup_sel, cfg_startup_fast,
                     cfg_fast_freq};
        end
        default: prdata <= 32'h0;
      endcase
    end
  end

endmodule // cpmc_top

/* File: sim/cpmc_checker.sv */
// Purpose: port-level assertions for cpmc_top
// Assumes: oscillator ticks every cycle, clk_en held high
// Notes:   bound into every cpmc_top instance
`timescale 1ns/1ps
module cpmc_checker (
  input wire       core_clk,
  input wire       rstn,
  input wire       cfg_inst_div4,
  input wire [2:0] cfg_fast_freq,
  input wire       ext_reset_pin_n,
  input wire       por_event,
  input wire       low_supply_reset,
  input wire       wdt_timeout,
  input wire       portb_change,
  input wire       ext_pin_irq,
  input wire       fast_osc_en,
  input wire       slow_osc_en,
  input wire [2:0] fast_freq_sel,
  input wire       inst_tick,
  input wire       cpu_run,
  input wire       periph_en,
  input wire       timer_en,
  input wire       core_reset
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // watchdog left out of pin_wake: in reset mode it restarts the sequence
  wire pin_wake = portb_change | ext_pin_irq;
  wire any_exit = pin_wake | wdt_timeout | !ext_reset_pin_n | por_event | low_supply_reset;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  freq_pass_a: assert property (
    !core_reset && $stable(cfg_fast_freq) |-> fast_freq_sel == cfg_fast_freq)
    else $error("fast frequency select not passed on");
  halt_quiet_a: assert property (
    !slow_osc_en |-> !fast_osc_en && !cpu_run && !periph_en && !timer_en)
    else $error("activity while both oscillators are off");
  slow_alive_a: assert property (
    cpu_run |-> slow_osc_en)
    else $error("slow oscillator off while executing");
  div_two_a: assert property (
    inst_tick && !cfg_inst_div4 |=> !inst_tick)
    else $error("instruction tick too close for div2");
  div_four_a: assert property (
    inst_tick && cfg_inst_div4 |=> !inst_tick [*3])
    else $error("instruction tick too close for div4");
  reset_entry_a: assert property (
    !ext_reset_pin_n || por_event || low_supply_reset |-> ##[1:4] core_reset)
    else $error("reset event did not start the sequence");
  pwrup_hold_a: assert property (
    $rose(ext_reset_pin_n) |=> core_reset [*8])
    else $error("reset sequence ended before power-up delay");
  halt_settle_a: assert property (
    !slow_osc_en && pin_wake |=> !cpu_run [*8] ##[8:40] cpu_run)
    else $error("halt wake settle time wrong");
  halt_exit_a: assert property (
    $rose(slow_osc_en) |-> $past(any_exit, 1) || $past(any_exit, 2) || $past(any_exit, 3))
    else $error("halt left without a wake source");
endmodule // cpmc_checker

bind cpmc_top cpmc_checker u_cpmc_checker (.core_clk, .rstn, .cfg_inst_div4, .cfg_fast_freq,
  .ext_reset_pin_n, .por_event, .low_supply_reset, .wdt_timeout, .portb_change, .ext_pin_irq,
  .fast_osc_en, .slow_osc_en, .fast_freq_sel, .inst_tick, .cpu_run, .periph_en, .timer_en,
  .core_reset);

/* File: sim/cpmc_top_tb.sv */
// Purpose: self-checking bench for cpmc_top
// Assumes: fast oscillator ticks every cycle, slow one except for a short gap, shortened power-up counts
// Notes:   sequencer state and flags are polled over apb
`timescale 1ns/1ps
`include "cpmc_regs.vh"
module cpmc_top_tb;
  // ------------------------------------------------------------
  // stimulus and observation
  // ------------------------------------------------------------
  logic        core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, r, rs = 32'h0000001b;
  logic        cfg_inst_div4 = 1'b0, cfg_startup_fast = 1'b0, cfg_t0_slow_src = 1'b0;
  logic [2:0]  cfg_fast_freq = 3'h0, cfg_pwrup_sel = 3'h0;
  logic        cfg_wdt_reset = 1'b0, global_irq_allow = 1'b0, to_n, pd_n, sel;
  logic [10:0] ev_q = 11'h000;
  wire [31:0]  prdata;
  logic        clk_en = 1'b1, fast_osc_tick = 1'b1, slow_osc_tick = 1'b1;
  logic [3:0]  pstrb = 4'hf;
  wire         pready, fast_osc_en, slow_osc_en, sys_clk_fast, cpu_run, wake_vector, core_reset;
  wire         pslverr, inst_tick, periph_en, timer_en, timer0_slow_clk, wdt_clear;
  wire [2:0]   fast_freq_sel;
  int          err_count = 0, n_tests = 0, wv_cnt = 0, wc_cnt = 0, k, c, n, m;
  int          rk[4] = '{8, 9, 10, 2};

  cpmc_top #(.PWRUP_140U_CYC(8), .PWRUP_4M5_CYC(12), .PWRUP_18M_CYC(16), .PWRUP_72M_CYC(20),
    .PWRUP_288M_CYC(24), .SETTLE_CYC(16)) u_cpmc_top (.core_clk, .rstn, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
    .fast_osc_tick, .slow_osc_tick, .cfg_inst_div4, .cfg_fast_freq,
    .cfg_startup_fast, .cfg_pwrup_sel, .cfg_t0_slow_src, .cfg_wdt_reset,
    .por_event(ev_q[8]), .low_supply_reset(ev_q[9]), .ext_reset_pin_n(!ev_q[10]),
    .wdt_timeout(ev_q[2]), .sleep_op(ev_q[6]), .watchdog_clear_op(ev_q[7]), .global_irq_allow,
    .timer0_ovf(ev_q[0]), .timer1_unf(ev_q[1]), .portb_change(ev_q[3]), .ext_pin_irq(ev_q[4]),
    .lvd_irq(ev_q[5]), .fast_osc_en, .slow_osc_en, .fast_freq_sel, .sys_clk_fast,
    .inst_tick, .cpu_run, .periph_en, .timer_en, .timer0_slow_clk, .wdt_clear,
    .wake_vector, .core_reset);

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (wake_vector === 1'b1) wv_cnt <= wv_cnt + 1;
  always @(posedge core_clk) if (wdt_clear === 1'b1) wc_cnt <= wc_cnt + 1;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic int pw(input logic [2:0] s);
    return (s > 3'h3) ? 24 : 8 + 4 * s;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk); penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata; psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wm(input logic [7:0] d);
    logic [31:0] j;
    j = xs();
    apb(1'b1, `CPMC_OFF_MODE, {j[31:8], d});
    repeat (3) @(posedge core_clk);
  endtask
  // polls until the state shows, then compares state and both flags
  task automatic st(input logic [2:0] s);
    int i;
    i = 0;
    do begin apb(1'b0, `CPMC_OFF_STATUS, 32'h0); i++; end while (rd[2:0] !== s && i < 100);
    chk(rd[4:0], {to_n, pd_n, s});
  endtask
  task automatic ev(input int e);
    ev_q[e] <= 1'b1; @(posedge core_clk); ev_q[e] <= 1'b0; @(posedge core_clk);
  endtask
  task automatic finish_test();
    $display("TB: errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    finish_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    r = xs(); to_n = 1'b1; pd_n = 1'b1;
    {cfg_inst_div4, cfg_fast_freq, cfg_startup_fast, cfg_pwrup_sel, cfg_t0_slow_src} <= r[8:0];
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    st(3'h3);
    chk(sys_clk_fast, cfg_startup_fast);
    apb(1'b1, `CPMC_OFF_CONFIG, r);
    apb(1'b0, `CPMC_OFF_CONFIG, 32'h0);
    chk(rd, {24'h0, cfg_inst_div4, cfg_pwrup_sel, cfg_startup_fast, cfg_fast_freq});
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    chk(pslverr, 1'b0);
    wm(8'h01); chk(sys_clk_fast, 1'b1);
    wm(8'h00); chk(sys_clk_fast, 1'b0);
    wm(8'h02); chk(fast_osc_en, 1'b0);
    wm(8'h01); chk(fast_osc_en, 1'b1);
    wm(8'h11); chk(timer0_slow_clk, cfg_t0_slow_src);
    slow_osc_tick <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(timer0_slow_clk, 1'b0);
    slow_osc_tick <= 1'b1;
    pstrb <= 4'he;
    apb(1'b1, `CPMC_OFF_MODE, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, `CPMC_OFF_MODE, 32'h0);
    chk(rd[7:0], 8'h11);
    for (k = 0; k < 6; k++) begin
      r = xs(); sel = r[0];
      wm({7'h00, sel});
      global_irq_allow <= r[1];
      wm({4'h0, 2'h2, 1'b0, sel});
      st(3'h4);
      apb(1'b0, `CPMC_OFF_MODE, 32'h0);
      chk(rd[3:2], 2'h2);
      chk(cpu_run, 1'b0);
      if (k == 0) begin
        clk_en <= 1'b0;
        ev(0);
        clk_en <= 1'b1;
        st(3'h4);
      end
      n = wv_cnt;
      ev(k);
      if (k == 2) to_n = 1'b0;
      st(3'h3);
      chk(sys_clk_fast, sel);
      chk(wv_cnt - n, r[1]);
    end
    for (k = 0; k < 3; k++) begin
      r = xs(); sel = r[0];
      wm({7'h00, sel});
      global_irq_allow <= r[1];
      m = wc_cnt;
      if (k == 1) ev(6);
      else wm({4'h0, 2'h1, ~sel, sel});
      to_n = 1'b1; pd_n = 1'b0;
      st(3'h5);
      chk(wc_cnt - m, 32'h1);
      ev(0); ev(1); ev(5);
      st(3'h5);
      n = wv_cnt;
      ev(k + 2);
      for (c = 0; c < 60 && cpu_run !== 1'b1; c++) @(posedge core_clk);
      chk(c > 12 && c < 24, 1'b1);
      if (k == 0) to_n = 1'b0;
      st(3'h3);
      chk(sys_clk_fast, sel);
      chk(wv_cnt - n, r[1]);
    end
    m = wc_cnt;
    ev(7); to_n = 1'b1; pd_n = 1'b1;
    st(3'h3);
    chk(wc_cnt - m, 32'h1);
    cfg_wdt_reset <= 1'b1;
    ev(2); to_n = 1'b0;
    st(3'h3);
    foreach (rk[i]) begin
      r = xs();
      cfg_pwrup_sel <= r[2:0];
      wm(8'h04); to_n = 1'b1; pd_n = 1'b0;
      st(3'h5);
      ev(rk[i]);
      for (c = 0; c < 200 && (c < 2 || core_reset !== 1'b0); c++) @(posedge core_clk);
      chk(c >= pw(r[2:0]) + 12 && c <= pw(r[2:0]) + 24, 1'b1);
      to_n = (rk[i] != 2); pd_n = to_n;
      st(3'h3);
    end
    finish_test();
  end
endmodule // cpmc_top_tb
